// File: lcf_sequencer.sv
// lcf_sequencer: per-channel strike, run and fault sequencing with push-pull gates
// assumes sys_clk_in is the lamp oscillator; device undervoltage drives reset_n_in
`timescale 1ns/1ns
`default_nettype none

module lcf_sequencer #(
    parameter int unsigned STRIKE_LIMIT  = lcf_pkg::STRIKE_CYCLES,
    parameter int unsigned LAMPOUT_LIMIT = lcf_pkg::LAMPOUT_CYCLES
) (
    input  wire logic sys_clk_in,
    input  wire logic reset_n_in,
    input  wire logic clk_en_in,
    input  wire logic inverter_supply_sense_in,
    input  wire logic burst_dimming_pwm_in,
    input  wire logic lamp_current_sense_ch1_in,
    input  wire logic lamp_out_sense_ch1_in,
    input  wire logic overcurrent_sense_ch1_in,
    input  wire logic overvoltage_sense_ch1_in,
    input  wire logic lamp_current_sense_ch2_in,
    input  wire logic lamp_out_sense_ch2_in,
    input  wire logic overcurrent_sense_ch2_in,
    input  wire logic overvoltage_sense_ch2_in,
    output logic      gate_drive_a_ch1_out,
    output logic      gate_drive_b_ch1_out,
    output logic      gate_drive_a_ch2_out,
    output logic      gate_drive_b_ch2_out,
    output logic      fault_ch1_out,
    output logic      fault_ch2_out
);

    typedef struct packed {
        lcf_pkg::lcf_sync_t      sync;
        lcf_pkg::lcf_chan_t [1:0] ch;
    } lcf_all_t;

    lcf_all_t state_r;
    lcf_all_t state_nxt;

    // window ends at the counter width; cut on purpose, 65536 still fits 17 bits
    localparam logic [16:0] STRIKE_TOP  = 17'(STRIKE_LIMIT);
    localparam logic [16:0] STRIKE_END  = 17'(STRIKE_LIMIT - 1);
    localparam logic [16:0] LAMPOUT_END = 17'(LAMPOUT_LIMIT - 1);

    always_comb
    begin
        logic                supply_ok;
        logic                dim_on;
        lcf_pkg::lcf_sense_t sn;
        lcf_pkg::lcf_chan_t  c;
        logic [7:0]          period;
        logic [3:0]          raw;
        state_nxt = state_r;
        supply_ok = 1'b0;
        dim_on    = 1'b0;
        sn        = '0;
        c         = '0;
        period    = lcf_pkg::PERIOD_RUN;
        raw       = '0;
        state_nxt.sync.supply_ok = {state_r.sync.supply_ok[1:0], inverter_supply_sense_in};
        state_nxt.sync.dim       = {state_r.sync.dim[1:0], burst_dimming_pwm_in};
        for (int k = 0; k < 3; k++)
        begin
            if (k == 0)
            begin
                state_nxt.sync.sense1[0] = {lamp_current_sense_ch1_in, lamp_out_sense_ch1_in,
                                            overcurrent_sense_ch1_in, overvoltage_sense_ch1_in};
                state_nxt.sync.sense2[0] = {lamp_current_sense_ch2_in, lamp_out_sense_ch2_in,
                                            overcurrent_sense_ch2_in, overvoltage_sense_ch2_in};
            end
            else
            begin
                state_nxt.sync.sense1[k] = state_r.sync.sense1[k-1];
                state_nxt.sync.sense2[k] = state_r.sync.sense2[k-1];
            end
        end
        // stages disagree only in a change; then hold off, which is the safe side
        supply_ok = state_r.sync.supply_ok[1] & state_r.sync.supply_ok[2];
        dim_on    = state_r.sync.dim[1] & state_r.sync.dim[2];
        for (int i = 0; i < 2; i++)
        begin
            for (int b = 0; b < 4; b++)
            begin
                if (i == 0)
                    raw[b] = (state_r.sync.sense1[1][b] == state_r.sync.sense1[2][b])
                           & state_r.sync.sense1[2][b];
                else
                    raw[b] = (state_r.sync.sense2[1][b] == state_r.sync.sense2[2][b])
                           & state_r.sync.sense2[2][b];
            end
            sn = raw;
            c  = state_r.ch[i];
            period = (c.state == lcf_pkg::LCF_STRIKE) ? lcf_pkg::PERIOD_STRIKE
                                                      : lcf_pkg::PERIOD_RUN;
            c.gate = '0;
            if (c.phase >= period - 8'h01)
            begin
                c.phase = 8'h00;
                c.half  = ~c.half;
            end
            else
                c.phase = c.phase + 8'h01;
            case (c.state)
                lcf_pkg::LCF_IDLE:
                begin
                    c.cnt  = lcf_pkg::CNT_RESET;
                    c.duty = lcf_pkg::DUTY_RESET;
                    if (supply_ok)
                        c.state = lcf_pkg::LCF_STRIKE;
                end
                lcf_pkg::LCF_STRIKE:
                begin
                    if (sn.overvoltage || sn.overcurrent)
                        c.state = lcf_pkg::LCF_FAULT;
                    else if (sn.current)
                    begin
                        c.state = lcf_pkg::LCF_RUN;
                        c.cnt   = lcf_pkg::CNT_RESET;
                    end
                    // strike timeout; count tested before the step, so the full window runs
                    else if (c.cnt >= STRIKE_END)
                        c.state = lcf_pkg::LCF_FAULT;
                    else
                    begin
                        c.cnt = c.cnt + 17'h00001;
                        if (c.phase == 8'h00 && c.duty < lcf_pkg::DUTY_MAX)
                            c.duty = c.duty + 6'h01;
                    end
                end
                lcf_pkg::LCF_RUN:
                begin
                    if (sn.overcurrent)
                        c.state = lcf_pkg::LCF_FAULT;
                    else if (!sn.lamp_out)
                        c.cnt = lcf_pkg::CNT_RESET;
                    else if (c.cnt >= LAMPOUT_END)
                        c.state = lcf_pkg::LCF_FAULT;
                    else
                        c.cnt = c.cnt + 17'h00001;
                    if (c.phase == 8'h00)
                    begin
                        if ((sn.current || sn.overvoltage) && c.duty != 6'h00)
                            c.duty = c.duty - 6'h01;
                        else if (!sn.current && c.duty < lcf_pkg::DUTY_MAX)
                            c.duty = c.duty + 6'h01;
                    end
                end
                lcf_pkg::LCF_FAULT:
                    c.cnt = lcf_pkg::CNT_RESET;
                default:
                    c.state = lcf_pkg::LCF_IDLE;
            endcase
            // supply loss clears to idle; per channel
            if (!supply_ok)
                c.state = lcf_pkg::LCF_IDLE;
            if ((c.state == lcf_pkg::LCF_STRIKE || c.state == lcf_pkg::LCF_RUN)
                && supply_ok && dim_on && c.phase < {c.duty, 2'b00} + 8'h01)
            begin
                c.gate.gate_a = ~c.half;
                c.gate.gate_b = c.half;
            end
            state_nxt.ch[i] = c;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            state_r <= '0;
        else if (clk_en_in)
            state_r <= state_nxt;
    end

    assign gate_drive_a_ch1_out = state_r.ch[0].gate.gate_a;
    assign gate_drive_b_ch1_out = state_r.ch[0].gate.gate_b;
    assign gate_drive_a_ch2_out = state_r.ch[1].gate.gate_a;
    assign gate_drive_b_ch2_out = state_r.ch[1].gate.gate_b;
    assign fault_ch1_out        = (state_r.ch[0].state == lcf_pkg::LCF_FAULT);
    assign fault_ch2_out        = (state_r.ch[1].state == lcf_pkg::LCF_FAULT);

    gates_exclusive_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        !(gate_drive_a_ch1_out && gate_drive_b_ch1_out)) else $error("ch1 gates overlap");
    fault_gates_off_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        fault_ch1_out |-> !gate_drive_a_ch1_out && !gate_drive_b_ch1_out)
        else $error("gate on in fault");
    fault_latched_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        fault_ch2_out && clk_en_in && state_r.sync.supply_ok[1] && state_r.sync.supply_ok[2]
        |=> fault_ch2_out) else $error("fault released without supply loss");
    dim_gates_off_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        clk_en_in && !state_r.sync.dim[2] |=> !gate_drive_a_ch2_out && !gate_drive_b_ch2_out)
        else $error("gate on in dim low");
    duty_bounded_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        state_r.ch[0].duty <= lcf_pkg::DUTY_MAX) else $error("duty above limit");
    supply_gates_off_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        clk_en_in && !state_r.sync.supply_ok[2] |=> !gate_drive_a_ch1_out
        && !gate_drive_b_ch1_out) else $error("gate on without supply");
    strike_count_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        state_r.ch[0].state == lcf_pkg::LCF_STRIKE |-> state_r.ch[0].cnt < STRIKE_TOP)
        else $error("strike over limit");
    // ch2 keeps running when ch1 faults and its own senses are quiet
    chan_indep_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        clk_en_in && $rose(fault_ch1_out) && state_r.ch[1].state == lcf_pkg::LCF_RUN
        && state_r.sync.supply_ok[1] && state_r.sync.supply_ok[2]
        && !state_r.sync.sense2[2][1] && !state_r.sync.sense2[2][2]
        |=> state_r.ch[1].state == lcf_pkg::LCF_RUN) else $error("fault spread");

    strike_c: cover property (@(posedge sys_clk_in) state_r.ch[0].state == lcf_pkg::LCF_RUN);
    fault_c:  cover property (@(posedge sys_clk_in) fault_ch1_out);
    drive_c:  cover property (@(posedge sys_clk_in) gate_drive_b_ch2_out);

endmodule
`default_nettype wire

// File: lcf_pkg.sv
// lcf_pkg: constants and types for the two-channel lamp sequencer
// assumes one clock, comparator results arrive as asynchronous levels
package lcf_pkg;

    // strike and lamp-out windows, counted in lamp oscillator cycles
    localparam int unsigned STRIKE_CYCLES   = 65536;
    localparam int unsigned LAMPOUT_CYCLES  = 65536;
    localparam int          CNT_W           = 17;
    localparam int          DUTY_W          = 6;
    // half lamp period in ticks; strike half period is 3/4 of it (33% boost)
    localparam logic [7:0]  PERIOD_RUN      = 8'h10;
    localparam logic [7:0]  PERIOD_STRIKE   = 8'h0C;
    localparam logic [5:0]  DUTY_RESET      = 6'h00;
    localparam logic [5:0]  DUTY_MAX        = 6'h07;
    localparam logic [16:0] CNT_RESET       = 17'h00000;

    typedef enum logic [1:0] {
        LCF_IDLE,
        LCF_STRIKE,
        LCF_RUN,
        LCF_FAULT
    } lcf_state_t;

    // synchronised comparator results of one channel
    typedef struct packed {
        logic current;
        logic lamp_out;
        logic overcurrent;
        logic overvoltage;
    } lcf_sense_t;

    typedef struct packed {
        logic gate_a;
        logic gate_b;
    } lcf_gate_t;

    typedef struct packed {
        lcf_state_t  state;
        logic [16:0] cnt;
        logic [5:0]  duty;
        logic [7:0]  phase;
        logic        half;
        lcf_gate_t   gate;
    } lcf_chan_t;

    typedef struct packed {
        logic [2:0] supply_ok;
        logic [2:0] dim;
        logic [2:0][3:0] sense1;
        logic [2:0][3:0] sense2;
    } lcf_sync_t;

endpackage

// File: lcf_lamp_model.sv
// lcf_lamp_model: lamp, transformer and current sense of one channel
// assumes gate levels from the sequencer; strike and open knobs from the bench
`timescale 1ns/1ns
`default_nettype none
module lcf_lamp_model (
    input  wire logic clk_in,
    input  wire logic gate_a_in,
    input  wire logic gate_b_in,
    input  wire logic can_strike_in,
    input  wire logic open_in,
    output logic      current_out,
    output logic      lamp_out_out
);
    logic [1:0] pulses_r;
    logic       struck_r;
    // strikes only after some real drive, so an idle sequencer never lights it
    always_ff @(posedge clk_in)
    begin
        if (!can_strike_in)
        begin
            pulses_r <= 2'h0;
            struck_r <= 1'b0;
        end
        else if ((gate_a_in || gate_b_in) && !struck_r)
        begin
            pulses_r <= pulses_r + 2'h1;
            struck_r <= (pulses_r == 2'h2);
        end
    end
    assign current_out  = struck_r && !open_in;
    assign lamp_out_out = !current_out;
endmodule
`default_nettype wire

// File: lcf_sequencer_bench.sv
// lcf_sequencer_bench: scenario tasks for the two-channel lamp sequencer
// assumes shortened strike and lamp-out limits; one lamp model per channel
`timescale 1ns/1ns
`default_nettype none
module lcf_sequencer_bench;
    localparam int LIM = 50;
    logic       sys_clk = 1'b0;
    logic       rst_n = 1'b0;
    logic       sup = 1'b0;
    logic       dim = 1'b1;
    logic [1:0] strk = 2'h0;
    logic [1:0] opn = 2'h0;
    logic [1:0] ovc = 2'h0;
    logic [1:0] ovv = 2'h0;
    logic [1:0] ga, gb, flt, cur, lo;
    logic [1:0] ga_q = 2'h0;
    int         edges [2] = '{0, 0};
    int         cyc = 0;
    int         last = 0;
    int         per = 0;
    int         err_count = 0;
    int         n_checks = 0;

    lcf_sequencer #(.STRIKE_LIMIT(LIM), .LAMPOUT_LIMIT(LIM)) i_dut (
        .sys_clk_in(sys_clk), .reset_n_in(rst_n), .clk_en_in(1'b1),
        .inverter_supply_sense_in(sup), .burst_dimming_pwm_in(dim),
        .lamp_current_sense_ch1_in(cur[0]), .lamp_out_sense_ch1_in(lo[0]),
        .overcurrent_sense_ch1_in(ovc[0]), .overvoltage_sense_ch1_in(ovv[0]),
        .lamp_current_sense_ch2_in(cur[1]), .lamp_out_sense_ch2_in(lo[1]),
        .overcurrent_sense_ch2_in(ovc[1]), .overvoltage_sense_ch2_in(ovv[1]),
        .gate_drive_a_ch1_out(ga[0]), .gate_drive_b_ch1_out(gb[0]),
        .gate_drive_a_ch2_out(ga[1]), .gate_drive_b_ch2_out(gb[1]),
        .fault_ch1_out(flt[0]), .fault_ch2_out(flt[1]));
    lcf_lamp_model i_lamp1 (.clk_in(sys_clk), .gate_a_in(ga[0]), .gate_b_in(gb[0]),
        .can_strike_in(strk[0]), .open_in(opn[0]), .current_out(cur[0]),
        .lamp_out_out(lo[0]));
    lcf_lamp_model i_lamp2 (.clk_in(sys_clk), .gate_a_in(ga[1]), .gate_b_in(gb[1]),
        .can_strike_in(strk[1]), .open_in(opn[1]), .current_out(cur[1]),
        .lamp_out_out(lo[1]));

    always #50 sys_clk = ~sys_clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        ga_q <= ga;
        for (int c = 0; c < 2; c++)
            if (ga[c] && !ga_q[c])
                edges[c] <= edges[c] + 1;
        if (ga[0] && !ga_q[0])
        begin
            per <= cyc - last;
            last <= cyc;
        end
        chk({ga[1] & gb[1], ga[0] & gb[0]}, 2'h0);
        if (cyc == 5000)
        begin
            err_count++;
            results();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #10;
    endtask

    // does each channel show gate activity over n cycles
    task automatic gates(input int n, input logic [1:0] exp);
        int e0, e1;
        e0 = edges[0];
        e1 = edges[1];
        tick(n);
        chk({edges[1] != e1, edges[0] != e0}, exp);
    endtask

    task automatic start(input logic [1:0] s);
        rst_n = 1'b0;
        strk = 2'h0;
        {opn, ovc, ovv} = 6'h00;
        dim = 1'b1;
        sup = 1'b1;
        tick(2);
        chk({ga, gb, flt}, 6'h00);
        strk = s;
        rst_n = 1'b1;
    endtask

    task automatic t_supply();
        start(2'h3);
        sup = 1'b0;
        gates(60, 2'h0);
    endtask

    task automatic t_run();
        start(2'h3);
        gates(40, 2'h3);
        tick(80);
        chk(flt, 2'h0);
        chk(per, 2 * lcf_pkg::PERIOD_RUN);
        sup = 1'b0;
        tick(6);
        gates(30, 2'h0);
    endtask

    task automatic t_nostrike();
        start(2'h2);
        // four edges of supply sync before strike, then the full strike window
        tick(LIM + 3);
        chk(flt, 2'h0);
        tick(1);
        chk(flt, 2'h1);
        chk(per, 2 * lcf_pkg::PERIOD_STRIKE);
        gates(40, 2'h2);
        sup = 1'b0;
        tick(8);
        chk(flt, 2'h0);
    endtask

    task automatic t_overvolt();
        start(2'h0);
        tick(10);
        ovv = 2'h1;
        tick(6);
        chk(flt, 2'h1);
        chk({ga[0], gb[0]}, 2'h0);
    endtask

    task automatic t_lamp_out();
        start(2'h3);
        tick(80);
        opn = 2'h1;
        tick(45);
        chk(flt, 2'h0);
        opn = 2'h0;
        tick(8);
        opn = 2'h1;
        tick(45);
        chk(flt, 2'h0);
        tick(30);
        chk(flt, 2'h1);
        gates(40, 2'h2);
    endtask

    task automatic t_overcur();
        start(2'h3);
        tick(80);
        ovc = 2'h2;
        tick(6);
        chk(flt, 2'h2);
        ovc = 2'h0;
        tick(60);
        chk(flt, 2'h2);
        gates(40, 2'h1);
    endtask

    task automatic t_dim();
        start(2'h3);
        tick(80);
        dim = 1'b0;
        tick(5);
        gates(40, 2'h0);
        dim = 1'b1;
        gates(40, 2'h3);
    endtask

    initial
    begin
        tick(4);
        t_supply();
        t_run();
        t_nostrike();
        t_overvolt();
        t_lamp_out();
        t_overcur();
        t_dim();
        results();
    end
endmodule
`default_nettype wire
